//--- hdl/port9_function_select.v
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "port9_map.vh"

module port9_function_select
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata_r,
   output reg         hreadyout_r,
   output reg         hresp_r,
   input  wire [15:0] port_out_data,
   input  wire [15:0] port_dir_out,
   input  wire [15:0] separate_bus_address_bits,
   input  wire        serial3_clock_out,
   input  wire        serial3_clock_oe_n,
   input  wire        serial3_out,
   input  wire        serial2_clock_out,
   input  wire        serial2_clock_oe_n,
   input  wire        serial2_out,
   input  wire        uart1_transmit,
   input  wire        timer_output_five,
   input  wire        timer_output_four,
   input  wire        timer_output_three,
   input  wire        timer_output_two,
   input  wire [15:0] pin_in,
   output reg  [15:0] pin_out_r,
   output reg  [15:0] pin_oe_n_r,
   output reg  [15:0] port_pin_level_r,
   output reg         serial3_clock_in_r,
   output reg         serial3_in_r,
   output reg         serial2_clock_in_r,
   output reg         serial2_in_r,
   output reg         uart1_receive_r,
   output reg         external_irq_six_r,
   output reg         external_irq_five_r
);

   wire [15:0] pin_mode_select;
   wire [15:0] pin_function_select;

   reg         wr_pend_r;
   reg         rd_pend_r;
   reg [`ADDR_MSB:0] addr_r;
   reg         byte_r;

   reg         mode_wr_lo;
   reg         mode_wr_hi;
   reg         func_wr_lo;
   reg         func_wr_hi;
   reg [15:0]  wr_data;
   reg [31:0]  rd_data;

   reg [15:0]  pin_out_nxt;
   reg [15:0]  pin_oe_n_nxt;
   integer     i;

   wire        take = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

   // True when pin n is in control mode with its alternate function chosen
   function alt_sel;
      input [15:0] mode;
      input [15:0] func;
      input integer n;
      begin
         alt_sel = mode[n] & func[n];
      end
   endfunction

   // Places the upper byte of a half-register value, or the whole value, into the low bits, upper bits zero
   function [31:0] half_word;
      input [15:0] val;
      input        upper;
      begin
         if (upper)
         begin
            half_word = {24'h000000, val[15:8]};
         end
         else
         begin
            half_word = {16'h0000, val};
         end
      end
   endfunction

   // Address phase capture; reads take one wait state so a write just
   // committed is always seen by a following read
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r   <= 1'b0;
         rd_pend_r   <= 1'b0;
         addr_r      <= {(`ADDR_MSB+1){1'b0}};
         byte_r      <= 1'b0;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
         hrdata_r    <= 32'h00000000;
      end
      else
      begin
         hresp_r <= 1'b0;
         if (rd_pend_r)
         begin
            hrdata_r    <= rd_data;
            hreadyout_r <= 1'b1;
            rd_pend_r   <= 1'b0;
            wr_pend_r   <= 1'b0;
         end
         else if (take)
         begin
            addr_r      <= haddr[`ADDR_MSB:0];
            byte_r      <= (hsize == `HSIZE_BYTE);
            wr_pend_r   <= hwrite;
            rd_pend_r   <= ~hwrite;
            hreadyout_r <= hwrite;
         end
         else
         begin
            wr_pend_r   <= 1'b0;
         end
      end
   end

   // Write decode; a byte write to the full address is the lower half,
   // so a whole-register write needs a halfword or word size
   always @*
   begin
      mode_wr_lo = 1'b0;
      mode_wr_hi = 1'b0;
      func_wr_lo = 1'b0;
      func_wr_hi = 1'b0;
      wr_data    = hwdata[15:0];
      if (wr_pend_r)
      begin
         case (addr_r)
            `MODE_FULL_ADDR:
            begin
               mode_wr_lo = 1'b1;
               mode_wr_hi = ~byte_r;
            end
            `MODE_UPPER_ADDR:
            begin
               mode_wr_hi = 1'b1;
               wr_data    = {hwdata[7:0], 8'h00};
            end
            `FUNC_FULL_ADDR:
            begin
               func_wr_lo = 1'b1;
               func_wr_hi = ~byte_r;
            end
            `FUNC_UPPER_ADDR:
            begin
               func_wr_hi = 1'b1;
               wr_data    = {hwdata[7:0], 8'h00};
            end
            default:
            begin
               wr_data = hwdata[15:0];
            end
         endcase
      end
   end

   // Read decode; unmapped addresses read zero with an OKAY answer
   always @*
   begin
      case (addr_r)
         `MODE_FULL_ADDR:   rd_data = half_word(pin_mode_select, 1'b0);
         `MODE_UPPER_ADDR:  rd_data = half_word(pin_mode_select, 1'b1);
         `FUNC_FULL_ADDR:   rd_data = half_word(pin_function_select, 1'b0);
         `FUNC_UPPER_ADDR:  rd_data = half_word(pin_function_select, 1'b1);
         default:           rd_data = 32'h00000000;
      endcase
      if (byte_r && (addr_r == `MODE_FULL_ADDR || addr_r == `FUNC_FULL_ADDR))
      begin
         rd_data = {24'h000000, rd_data[7:0]};
      end
   end

   half_reg
   #(
      .RESET_VAL (`MODE_RESET),
      .WMASK     (`MODE_WMASK)
   )
   u_mode
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_lo   (mode_wr_lo),
      .wr_hi   (mode_wr_hi),
      .din     (wr_data),
      .q_r     (pin_mode_select)
   );

   // Missing bits 1 and 0 are masked so they always read zero
   half_reg
   #(
      .RESET_VAL (`FUNC_RESET),
      .WMASK     (`FUNC_WMASK)
   )
   u_func
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_lo   (func_wr_lo),
      .wr_hi   (func_wr_hi),
      .din     (wr_data),
      .q_r     (pin_function_select)
   );

   // Pin mux. Outputs are registered, so a new setting reaches the pins
   // one cycle after the register changes. Writing mode before clearing
   // function briefly shows alternate functions on the pins.
   always @*
   begin
      for (i = 0; i < 16; i = i + 1)
      begin
         if (!pin_mode_select[i])
         begin
            pin_out_nxt[i]  = port_out_data[i];
            pin_oe_n_nxt[i] = ~port_dir_out[i];
         end
         else
         begin
            pin_out_nxt[i]  = separate_bus_address_bits[i];
            pin_oe_n_nxt[i] = 1'b0;
         end
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER3_CLK))
      begin
         pin_out_nxt[`PIN_SER3_CLK]  = serial3_clock_out;
         pin_oe_n_nxt[`PIN_SER3_CLK] = serial3_clock_oe_n;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER3_OUT))
      begin
         pin_out_nxt[`PIN_SER3_OUT]  = serial3_out;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER3_IN))
      begin
         pin_out_nxt[`PIN_SER3_IN]   = 1'b0;
         pin_oe_n_nxt[`PIN_SER3_IN]  = 1'b1;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER2_CLK))
      begin
         pin_out_nxt[`PIN_SER2_CLK]  = serial2_clock_out;
         pin_oe_n_nxt[`PIN_SER2_CLK] = serial2_clock_oe_n;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER2_OUT))
      begin
         pin_out_nxt[`PIN_SER2_OUT]  = serial2_out;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_SER2_IN))
      begin
         pin_out_nxt[`PIN_SER2_IN]   = 1'b0;
         pin_oe_n_nxt[`PIN_SER2_IN]  = 1'b1;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_UART1_TX))
      begin
         pin_out_nxt[`PIN_UART1_TX]  = uart1_transmit;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_UART1_RX))
      begin
         pin_out_nxt[`PIN_UART1_RX]  = 1'b0;
         pin_oe_n_nxt[`PIN_UART1_RX] = 1'b1;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_TIMER5))
      begin
         pin_out_nxt[`PIN_TIMER5]    = timer_output_five;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_TIMER4))
      begin
         pin_out_nxt[`PIN_TIMER4]    = timer_output_four;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_TIMER3))
      begin
         pin_out_nxt[`PIN_TIMER3]    = timer_output_three;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_TIMER2))
      begin
         pin_out_nxt[`PIN_TIMER2]    = timer_output_two;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_IRQ6))
      begin
         pin_out_nxt[`PIN_IRQ6]      = 1'b0;
         pin_oe_n_nxt[`PIN_IRQ6]     = 1'b1;
      end
      if (alt_sel(pin_mode_select, pin_function_select, `PIN_IRQ5))
      begin
         pin_out_nxt[`PIN_IRQ5]      = 1'b0;
         pin_oe_n_nxt[`PIN_IRQ5]     = 1'b1;
      end
   end

   // Peripheral inputs idle at a quiet level when their pin is not given
   // to them: serial and uart lines high, interrupt requests low
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_out_r           <= 16'h0000;
         pin_oe_n_r          <= 16'hFFFF;
         port_pin_level_r    <= 16'h0000;
         serial3_clock_in_r  <= 1'b1;
         serial3_in_r        <= 1'b1;
         serial2_clock_in_r  <= 1'b1;
         serial2_in_r        <= 1'b1;
         uart1_receive_r     <= 1'b1;
         external_irq_six_r  <= 1'b0;
         external_irq_five_r <= 1'b0;
      end
      else
      begin
         pin_out_r        <= pin_out_nxt;
         pin_oe_n_r       <= pin_oe_n_nxt;
         port_pin_level_r <= pin_in;
         serial3_clock_in_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_SER3_CLK) ?
            pin_in[`PIN_SER3_CLK] : 1'b1;
         serial3_in_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_SER3_IN) ?
            pin_in[`PIN_SER3_IN] : 1'b1;
         serial2_clock_in_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_SER2_CLK) ?
            pin_in[`PIN_SER2_CLK] : 1'b1;
         serial2_in_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_SER2_IN) ?
            pin_in[`PIN_SER2_IN] : 1'b1;
         uart1_receive_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_UART1_RX) ?
            pin_in[`PIN_UART1_RX] : 1'b1;
         external_irq_six_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_IRQ6) ?
            pin_in[`PIN_IRQ6] : 1'b0;
         external_irq_five_r <=
            alt_sel(pin_mode_select, pin_function_select, `PIN_IRQ5) ?
            pin_in[`PIN_IRQ5] : 1'b0;
      end
   end

endmodule

//--- hdl/port9_map.vh
`ifndef PORT9_MAP_VH
`define PORT9_MAP_VH

// Register indices; byte address is four times the index
`define MODE_FULL_IDX        12'h452
`define MODE_UPPER_IDX       12'h453
`define FUNC_FULL_IDX        12'h472
`define FUNC_UPPER_IDX       12'h473

// Byte addresses on the bus (index times four)
`define MODE_FULL_ADDR       14'h1148
`define MODE_UPPER_ADDR      14'h114C
`define FUNC_FULL_ADDR       14'h11C8
`define FUNC_UPPER_ADDR      14'h11CC
`define ADDR_MSB             13

// Reset values
`define MODE_RESET           16'h0000
`define FUNC_RESET           16'h0000

// Implemented bits; function bits 1 and 0 do not exist
`define MODE_WMASK           16'hFFFF
`define FUNC_WMASK           16'hFFFC

// Half positions
`define HALF_LO_LSB          0
`define HALF_HI_LSB          8

// Pin positions of the alternate functions and of address bits 1 and 0
`define PIN_SER3_CLK         15
`define PIN_SER3_OUT         14
`define PIN_SER3_IN          13
`define PIN_SER2_CLK         12
`define PIN_SER2_OUT         11
`define PIN_SER2_IN          10
`define PIN_UART1_TX         9
`define PIN_UART1_RX         8
`define PIN_TIMER5           7
`define PIN_TIMER4           6
`define PIN_TIMER3           5
`define PIN_TIMER2           4
`define PIN_IRQ6             3
`define PIN_IRQ5             2
`define PIN_ADDR1            1
`define PIN_ADDR0            0

// Bus codes
`define HSIZE_BYTE           3'h0
`define HTRANS_NONSEQ_BIT    1

`endif

//--- hdl/half_reg.v
`timescale 1ns/100ps
// 16-bit control register written as a whole or per byte half
module half_reg
#(
   parameter [15:0] RESET_VAL = 16'h0000,
   parameter [15:0] WMASK     = 16'hFFFF
)
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        wr_lo,
   input  wire        wr_hi,
   input  wire [15:0] din,
   output reg  [15:0] q_r
);

   reg [15:0] q_nxt;

   always @*
   begin
      q_nxt = q_r;
      if (wr_lo)
      begin
         q_nxt[7:0] = din[7:0];
      end
      if (wr_hi)
      begin
         q_nxt[15:8] = din[15:8];
      end
      q_nxt = q_nxt & WMASK;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q_r <= RESET_VAL;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

endmodule

//--- sim/port9_function_select_assertions.sv
`timescale 1ns/100ps
`include "port9_map.vh"
module p9_checker
(
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire        hreadyout_r,
   input wire [15:0] port_out_data,
   input wire [15:0] port_dir_out,
   input wire [15:0] separate_bus_address_bits,
   input wire        timer_output_five,
   input wire        timer_output_four,
   input wire        timer_output_three,
   input wire        timer_output_two,
   input wire [15:0] pin_in,
   input wire [15:0] pin_out_r,
   input wire [15:0] pin_oe_n_r,
   input wire        uart1_receive_r,
   input wire        external_irq_six_r
);
   logic        av, aw, ab;
   logic [13:0] aa;
   logic [15:0] mode_s, func_s;
   wire  [15:0] alt = mode_s & func_s;
   wire  [15:0] adr = mode_s & ~func_s;
   wire         take = hsel && hready && htrans[1];
   // Shadow of both registers, rebuilt from the bus so pin checks need no internals
   function automatic logic [15:0] upd(input logic [15:0] o, input logic [13:0] f);
      upd = aa == f ? (ab ? {o[15:8], hwdata[7:0]} : hwdata[15:0]) :
            aa == f + 14'h0004 ? {hwdata[7:0], o[7:0]} : o;
   endfunction
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         av     <= 1'b0;
         mode_s <= 16'h0000;
         func_s <= 16'h0000;
      end
      else
      begin
         av <= take;
         aw <= hwrite;
         aa <= haddr[13:0];
         ab <= hsize == `HSIZE_BYTE;
         if (av && aw && hready)
         begin
            mode_s <= upd(mode_s, `MODE_FULL_ADDR);
            func_s <= upd(func_s, `FUNC_FULL_ADDR) & 16'hFFFC;
         end
      end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_port_data: assert property (
      $past(hresetn) |-> !((pin_out_r ^ $past(port_out_data)) & ~$past(mode_s)))
      else $error("port data");
   a_port_dir: assert property (
      $past(hresetn) |-> !((pin_oe_n_r ^ ~$past(port_dir_out)) & ~$past(mode_s)))
      else $error("port dir");
   a_addr_out: assert property (
      !(((pin_out_r ^ $past(separate_bus_address_bits)) | pin_oe_n_r) & $past(adr)))
      else $error("address route");
   a_timer_out: assert property (
      !((pin_out_r[7:4] ^ $past({timer_output_five, timer_output_four,
      timer_output_three, timer_output_two})) & $past(alt[7:4]))) else $error("timer route");
   a_in_float: assert property (
      !(~pin_oe_n_r & $past(alt) & 16'h250C)) else $error("input pin driven");
   a_irq_six: assert property (
      external_irq_six_r == ($past(alt[3]) && $past(pin_in[3]))) else $error("irq route");
   a_uart_rx: assert property (
      uart1_receive_r == (!$past(alt[8]) || $past(pin_in[8]))) else $error("rx route");
   a_read_wait: assert property (
      take && !hwrite |=> !hreadyout_r ##1 hreadyout_r) else $error("read wait");
   a_write_fast: assert property (
      take && hwrite |=> hreadyout_r) else $error("write wait");
   c_full_addr: cover property (mode_s == 16'hFFFF && func_s == 16'h0000);
   c_all_alt: cover property (alt == 16'hFFFC);
   c_read: cover property (take && !hwrite);
endmodule

//--- sim/far_side_model.sv
`timescale 1ns/100ps
module far_side_model
(
   input  wire         hclk,
   input  wire  [15:0] pin_out_r,
   input  wire  [15:0] pin_oe_n_r,
   output logic [63:0] drive,
   output wire  [15:0] pin_in
);
   // Peripherals and pins move every cycle so a stale route cannot match for long
   initial drive = 64'h0123456789ABCDEF;
   always @(posedge hclk)
      drive <= {drive[62:0], drive[63] ^ drive[62] ^ drive[60] ^ drive[59]};
   // Released pins float to a fresh pattern, not the last driven level
   assign pin_in = (~pin_oe_n_r & pin_out_r) | (pin_oe_n_r & (~drive[15:0] ^ drive[47:32]));
endmodule

//--- sim/port9_function_select_bench.sv
`timescale 1ns/100ps
`include "port9_map.vh"
module port9_function_select_bench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [31:0] hwdata = 32'h00000000;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   wire         hready, hreadyout_r, hresp_r, uart1_receive_r, external_irq_six_r;
   wire         serial3_clock_in_r, serial3_in_r, serial2_clock_in_r, serial2_in_r;
   wire         external_irq_five_r, serial3_clock_out, serial3_clock_oe_n, serial3_out;
   wire         serial2_clock_out, serial2_clock_oe_n, serial2_out, uart1_transmit;
   wire         timer_output_five, timer_output_four, timer_output_three, timer_output_two;
   wire  [31:0] hrdata_r;
   wire  [15:0] port_out_data, port_dir_out, separate_bus_address_bits;
   wire  [15:0] pin_in, pin_out_r, pin_oe_n_r, port_pin_level_r;
   wire  [63:0] drive;
   logic [15:0] m_mode = 16'h0000, m_func = 16'h0000, p_adr, p_pin;
   logic [3:0]  p_tim;
   logic [6:0]  p_ser;
   logic [31:0] seed = 32'h000011F8, rd, x;
   logic [13:0] adrs [5] = '{`MODE_FULL_ADDR, `MODE_UPPER_ADDR, `FUNC_FULL_ADDR,
                             `FUNC_UPPER_ADDR, 14'h1150};
   int          fail_count = 0, compares = 0, cyc = 0;
   assign hready = hreadyout_r;
   assign {port_out_data, port_dir_out, separate_bus_address_bits} = drive[47:0];
   assign {serial3_clock_out, serial3_clock_oe_n, serial3_out, serial2_clock_out,
           serial2_clock_oe_n, serial2_out, uart1_transmit, timer_output_five,
           timer_output_four, timer_output_three, timer_output_two} = drive[58:48];
   port9_function_select dut (.*);
   far_side_model far (.*);
   always #2.5 hclk = ~hclk;
   always @(posedge hclk)
   begin
      p_adr <= separate_bus_address_bits;
      p_pin <= pin_in;
      p_tim <= {timer_output_five, timer_output_four, timer_output_three, timer_output_two};
      p_ser <= {serial3_clock_out, serial3_clock_oe_n, serial3_out, serial2_clock_out,
                serial2_clock_oe_n, serial2_out, uart1_transmit};
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         print_verdict();
      end
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [15:0] upd(input logic [15:0] o, input logic [13:0] a, f,
                             input logic b, input logic [15:0] d);
      return a == f ? (b ? {o[15:8], d[7:0]} : d) : a == f + 14'h0004 ? {d[7:0], o[7:0]} : o;
   endfunction
   function logic [31:0] view(input logic [15:0] r, input logic [13:0] a, f, input logic b);
      return a == f ? (b ? {24'h000000, r[7:0]} : {16'h0000, r}) :
             a == f + 14'h0004 ? {24'h000000, r[15:8]} : 32'h00000000;
   endfunction
   task check(input logic [31:0] seen, exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic [13:0] a, input logic w, b, input logic [15:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {18'h00000, a};
      hwrite <= w;
      hsize <= b ? `HSIZE_BYTE : 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0000, d};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata_r;
      if (w)
      begin
         m_mode = upd(m_mode, a, `MODE_FULL_ADDR, b, d);
         m_func = upd(m_func, a, `FUNC_FULL_ADDR, b, d) & 16'hFFFC;
      end
   endtask
   task rchk(input logic [13:0] a, input logic b);
      bus(a, 1'b0, b, 16'h0000);
      check(rd, view(m_mode, a, `MODE_FULL_ADDR, b) |
            view(m_func, a, `FUNC_FULL_ADDR, b), "read data");
      check(32'(hresp_r), 32'h00000000, "response");
   endtask
   task print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (adrs[i]) rchk(adrs[i], 1'b0);
      rchk(`FUNC_FULL_ADDR, 1'b1);
      $display("test reset_values done");
      bus(`FUNC_FULL_ADDR, 1'b1, 1'b0, 16'hFFFF);
      rchk(`FUNC_FULL_ADDR, 1'b0);
      bus(`MODE_UPPER_ADDR, 1'b1, 1'b0, 16'h00A5);
      rchk(`MODE_FULL_ADDR, 1'b0);
      bus(`FUNC_FULL_ADDR, 1'b1, 1'b1, 16'h1234);
      rchk(`FUNC_FULL_ADDR, 1'b0);
      $display("test half_access done");
      repeat (40)
      begin
         x = rnd();
         bus(adrs[x[18:16] % 5], 1'b1, x[20], x[15:0]);
         rchk(adrs[x[23:21] % 5], x[24]);
         repeat (3) @(posedge hclk);
      end
      $display("test random_access done");
      bus(`FUNC_FULL_ADDR, 1'b1, 1'b0, 16'h0000);
      bus(`MODE_FULL_ADDR, 1'b1, 1'b0, 16'hFFFF);
      repeat (2) @(posedge hclk);
      #1;
      check(32'(pin_out_r), 32'(p_adr), "address pins");
      check(32'(pin_oe_n_r), 32'h00000000, "address drive");
      check(32'({serial3_clock_in_r, serial3_in_r, serial2_clock_in_r, serial2_in_r,
            uart1_receive_r, external_irq_six_r, external_irq_five_r}), 32'h0000007C,
            "quiet inputs");
      bus(`FUNC_FULL_ADDR, 1'b1, 1'b0, 16'hFFFF);
      repeat (2) @(posedge hclk);
      #1;
      check(32'(pin_out_r[7:4]), 32'(p_tim), "timer pins");
      check(32'(pin_out_r), 32'({p_ser[6], p_ser[4], 1'b0, p_ser[3], p_ser[1], 1'b0,
            p_ser[0], 1'b0, p_tim, 2'b00, p_adr[1:0]}), "alternate pins");
      check(32'(pin_oe_n_r), 32'({p_ser[5], 2'b01, p_ser[2], 4'b0101, 4'h0, 4'b1100}),
            "alternate drive");
      check(32'({serial3_clock_in_r, serial3_in_r, serial2_clock_in_r, serial2_in_r,
            external_irq_six_r}), 32'({p_pin[15], p_pin[13], p_pin[12], p_pin[10], p_pin[3]}),
            "alternate inputs");
      check(32'(port_pin_level_r), 32'(p_pin), "pin levels");
      check(32'(uart1_receive_r), 32'(p_pin[8]), "uart receive");
      check(32'(external_irq_five_r), 32'(p_pin[2]), "irq five");
      $display("test control_mode done");
      print_verdict();
   end
endmodule
bind port9_function_select p9_checker chk (.*);
